// file: flic_pkg.sv
`default_nettype none
package flic_pkg;

  localparam int NSRC = 14;

  // sources in arbitration order, index 0 ranks highest
  typedef enum logic [3:0] {
    SRC_EXT0, SRC_BOD, SRC_WDT, SRC_T0, SRC_TWI, SRC_ADC, SRC_EXT1,
    SRC_KEY, SRC_T1, SRC_SER, SRC_PWM, SRC_SPI, SRC_T2, SRC_CAP
  } flic_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_LOAD = 2'b11
  } flic_state_t;

  // four clocks per machine cycle, C1..C4
  localparam int          CLK_PER_MC  = 4;
  localparam logic [1:0]  PHASE_FIRST = 2'h0;
  localparam logic [1:0]  PHASE_LAST  = 2'h3;
  // hardware call spans four machine cycles
  localparam int          CALL_MC     = 4;
  localparam logic [1:0]  CALL_MC_END = 2'(CALL_MC - 2);
  localparam int          GATE_BIT    = 7;
  localparam logic [3:0]  SVC_RESET   = 4'h0;
  localparam logic [15:0] VEC_RESET   = 16'h0000;

  // set where the enable bit lives in the extended register
  localparam logic [NSRC-1:0] SRC_EN_EXT  = 14'h3c94;
  // set where the priority pair lives in the extended registers
  localparam logic [NSRC-1:0] SRC_PRI_EXT = 14'h1c94;
  // sources that may wake from power-down whenever their own enable is set
  localparam logic [NSRC-1:0] SRC_WAKE    = 14'h00c7;

  localparam logic [2:0] SRC_EN_BIT [NSRC] = '{
    3'h0, 3'h5, 3'h4, 3'h1, 3'h0, 3'h6, 3'h2,
    3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2};
  localparam logic [2:0] SRC_PRI_BIT [NSRC] = '{
    3'h0, 3'h5, 3'h4, 3'h1, 3'h0, 3'h6, 3'h2,
    3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
  localparam logic [15:0] SRC_VECTOR [NSRC] = '{
    16'h0003, 16'h0043, 16'h0053, 16'h000b, 16'h0033, 16'h005b, 16'h0013,
    16'h003b, 16'h001b, 16'h0023, 16'h0073, 16'h004b, 16'h002b, 16'h0063};

endpackage : flic_pkg
`default_nettype wire

// file: flic_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module flic_arbiter (
  input  wire logic [flic_pkg::NSRC-1:0]      req,
  input  wire logic [flic_pkg::NSRC-1:0][1:0] level,
  output logic                                winValid,
  output flic_pkg::flic_src_t                 winIdx,
  output logic [1:0]                          winLevel
);
  import flic_pkg::*;

  // later hits overwrite earlier ones: highest level, then lowest index
  always_comb begin
    winValid = 1'b0;
    winIdx   = SRC_EXT0;
    winLevel = 2'h0;
    for (int lv = 0; lv < 4; lv++) begin
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (req[i] && (level[i] == 2'(lv))) begin // R4 R5
          winValid = 1'b1;
          winIdx   = flic_src_t'(4'(i));
          winLevel = 2'(lv);
        end
      end
    end
  end

endmodule : flic_arbiter
`default_nettype wire

// file: flic_ctrl.sv
// Overview of operation
// R1 - two priority bits give level 0 to 3; high bit outranks low bit
// R2 - running service preempted only by a strictly higher level
// R3 - level 3 service is never preempted
// R4 - simultaneous requests: the higher level wins
// R5 - same-level ties resolved by fixed ranking 1 to 14
// R6 - flags sampled, polled and resolved every machine cycle
// R7 - call only if no equal or higher service, on last instruction cycle
// R8 - no call while enable or priority written, or during return
// R9 - no pending memory; inactive flag at decision is not serviced
// R10 - call clears timer0/1 flags, external flags only in edge mode
// R11 - call pushes program counter only, then loads vector
// R12 - fixed vector address per source, 0003h to 0073h
// R13 - return from interrupt releases the completed level
// R14 - ordinary return leaves in-service state untouched
// R15 - per-source enables, global gate blocks every call but not wake-up
// R16 - listed sources wake from power-down; converter only on RC clock
// R17 - flags settled at C3 are polled in the following machine cycle
// R18 - call takes four machine cycles
// R19 - worst latency twelve machine cycles, 48 clocks
// R20 - priority pair at enable bit index; capture uses base bit 7
// R21 - arbitrated only when flag, own enable and global gate set
`timescale 1ns/1ns
`default_nettype none
module flic_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  baseEnableReg,
  input  wire logic [7:0]  extendedEnableReg,
  input  wire logic [7:0]  basePriorityLow,
  input  wire logic [7:0]  basePriorityHigh,
  input  wire logic [7:0]  extendedPriorityLow,
  input  wire logic [7:0]  extendedPriorityHigh,
  input  wire logic        ext0RequestFlag,
  input  wire logic        ext1RequestFlag,
  input  wire logic        ext0EdgeMode,
  input  wire logic        ext1EdgeMode,
  input  wire logic        timer0OverflowFlag,
  input  wire logic        timer1OverflowFlag,
  input  wire logic        timer2EventFlag,
  input  wire logic        serialRxFlag,
  input  wire logic        serialTxFlag,
  input  wire logic        brownoutFlag,
  input  wire logic        watchdogFlag,
  input  wire logic [7:0]  keypadFlags,
  input  wire logic [2:0]  captureFlags,
  input  wire logic        pwmBrakeFlag,
  input  wire logic        converterDoneFlag,
  input  wire logic        converterOnRc,
  input  wire logic        twoWireFlag,
  input  wire logic        spiFlag,
  input  wire logic        lastCycle,
  input  wire logic        writesIntReg,
  input  wire logic        returnFromInterrupt,
  output logic             cycleEnd,
  output logic             vectorCall,
  output logic             loadPc,
  output logic [15:0]      vectorAddr,
  output logic             callBusy,
  output logic [3:0]       inService,
  output logic             clrExt0Flag,
  output logic             clrExt1Flag,
  output logic             clrTimer0Flag,
  output logic             clrTimer1Flag,
  output logic             wakeRequest
);
  import flic_pkg::*;

  logic [1:0]            phase_q, phase_d;
  logic                  cycleEnd_q, cycleEnd_d;
  logic [NSRC-1:0]       sample_q, sample_d;
  logic [NSRC-1:0]       srcFlag, srcReq, srcWake;
  logic [NSRC-1:0][1:0]  srcLevel;
  logic                  winValid;
  flic_src_t             winIdx;
  logic [1:0]            winLevel;
  flic_state_t           state_q, state_d;
  logic [1:0]            mcCount_q, mcCount_d;
  flic_src_t             callIdx_q, callIdx_d;
  logic [1:0]            callLevel_q, callLevel_d;
  logic [3:0]            inService_q, inService_d;
  logic                  vectorCall_q, vectorCall_d;
  logic                  loadPc_q, loadPc_d;
  logic [15:0]           vectorAddr_q, vectorAddr_d;
  logic                  callBusy_q, callBusy_d;
  logic [3:0]            clr_q, clr_d;
  logic                  wake_q, wake_d;
  logic                  mcEnd, svcAny, allowed, startCall, retire;
  logic [1:0]            svcTop, maxReqLevel;

  assign mcEnd = (phase_q == PHASE_LAST);

  assign srcFlag = {|captureFlags, timer2EventFlag, spiFlag, pwmBrakeFlag,
                    serialRxFlag | serialTxFlag, timer1OverflowFlag,
                    |keypadFlags, ext1RequestFlag, converterDoneFlag,
                    twoWireFlag, timer0OverflowFlag, watchdogFlag,
                    brownoutFlag, ext0RequestFlag};

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      logic en, hi, lo;
      assign en = SRC_EN_EXT[i] ? extendedEnableReg[SRC_EN_BIT[i]]
                                : baseEnableReg[SRC_EN_BIT[i]];
      assign hi = SRC_PRI_EXT[i] ? extendedPriorityHigh[SRC_PRI_BIT[i]]
                                 : basePriorityHigh[SRC_PRI_BIT[i]]; // R20
      assign lo = SRC_PRI_EXT[i] ? extendedPriorityLow[SRC_PRI_BIT[i]]
                                 : basePriorityLow[SRC_PRI_BIT[i]]; // R20
      assign srcLevel[i] = {hi, lo}; // R1
      // R15 R21
      assign srcReq[i] = sample_q[i] & en & baseEnableReg[GATE_BIT];
      assign srcWake[i] = srcFlag[i] & en &
        (SRC_WAKE[i] | ((i == int'(SRC_ADC)) & converterOnRc)); // R16
    end
  endgenerate

  flic_arbiter u_arb (
    .req      (srcReq),
    .level    (srcLevel),
    .winValid (winValid),
    .winIdx   (winIdx),
    .winLevel (winLevel)
  );

  assign svcAny = |inService_q;
  always_comb begin
    svcTop = 2'h0;
    maxReqLevel = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (inService_q[l]) begin
        svcTop = 2'(l);
      end
    end
    for (int i = 0; i < NSRC; i++) begin
      if (srcReq[i] && srcLevel[i] > maxReqLevel) begin
        maxReqLevel = srcLevel[i];
      end
    end
  end

  // level 3 can never exceed svcTop, so it stays unbroken
  assign allowed = !svcAny || (winLevel > svcTop); // R2 R3 R7
  // decision at C4 from the previous machine cycle's samples only
  assign startCall = mcEnd && (state_q == ST_IDLE) && winValid && allowed
                     && lastCycle && !writesIntReg
                     && !returnFromInterrupt; // R6 R7 R8 R9 R19
  assign retire = mcEnd && (state_q == ST_IDLE) && lastCycle
                  && returnFromInterrupt; // R13 R14

  always_comb begin
    phase_d      = phase_q + 2'h1;
    cycleEnd_d   = (phase_d == PHASE_LAST);
    // flags present at C4 are polled through the next machine cycle
    sample_d     = mcEnd ? srcFlag : sample_q; // R6 R17
    state_d      = state_q;
    mcCount_d    = mcCount_q;
    callIdx_d    = callIdx_q;
    callLevel_d  = callLevel_q;
    inService_d  = inService_q;
    vectorCall_d = 1'b0;
    loadPc_d     = 1'b0;
    vectorAddr_d = vectorAddr_q;
    clr_d        = 4'h0;
    wake_d       = |srcWake; // R16
    unique case (state_q)
      ST_IDLE: begin
        if (startCall) begin
          state_d      = ST_CALL;
          mcCount_d    = 2'h0;
          callIdx_d    = winIdx;
          callLevel_d  = winLevel;
          vectorCall_d = 1'b1; // R11
          vectorAddr_d = SRC_VECTOR[winIdx]; // R12
          inService_d[winLevel] = 1'b1;
          clr_d = {winIdx == SRC_T1, winIdx == SRC_T0,
                   (winIdx == SRC_EXT1) && ext1EdgeMode,
                   (winIdx == SRC_EXT0) && ext0EdgeMode}; // R10
        end else if (retire) begin
          inService_d[svcTop] = 1'b0; // R13
        end
      end
      ST_CALL: begin
        if (mcEnd) begin
          mcCount_d = mcCount_q + 2'h1;
          if (mcCount_q == CALL_MC_END) begin
            state_d = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (mcEnd) begin
          state_d  = ST_IDLE;
          loadPc_d = 1'b1; // R11 R18
        end
      end
    endcase
    callBusy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q      <= PHASE_FIRST;
      cycleEnd_q   <= 1'b0;
      sample_q     <= '0;
      state_q      <= ST_IDLE;
      mcCount_q    <= 2'h0;
      callIdx_q    <= SRC_EXT0;
      callLevel_q  <= 2'h0;
      inService_q  <= SVC_RESET;
      vectorCall_q <= 1'b0;
      loadPc_q     <= 1'b0;
      vectorAddr_q <= VEC_RESET;
      callBusy_q   <= 1'b0;
      clr_q        <= 4'h0;
      wake_q       <= 1'b0;
    end else begin
      phase_q      <= phase_d;
      cycleEnd_q   <= cycleEnd_d;
      sample_q     <= sample_d;
      state_q      <= state_d;
      mcCount_q    <= mcCount_d;
      callIdx_q    <= callIdx_d;
      callLevel_q  <= callLevel_d;
      inService_q  <= inService_d;
      vectorCall_q <= vectorCall_d;
      loadPc_q     <= loadPc_d;
      vectorAddr_q <= vectorAddr_d;
      callBusy_q   <= callBusy_d;
      clr_q        <= clr_d;
      wake_q       <= wake_d;
    end
  end

  assign cycleEnd      = cycleEnd_q;
  assign vectorCall    = vectorCall_q;
  assign loadPc        = loadPc_q;
  assign vectorAddr    = vectorAddr_q;
  assign callBusy      = callBusy_q;
  assign inService     = inService_q;
  assign clrExt0Flag   = clr_q[0];
  assign clrExt1Flag   = clr_q[1];
  assign clrTimer0Flag = clr_q[2];
  assign clrTimer1Flag = clr_q[3];
  assign wakeRequest   = wake_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_pri_higher;
    vectorCall_q |-> callLevel_q == $past(maxReqLevel);
  endproperty
  a_pri_higher: assert property (p_pri_higher) // R1 R4
    else $error("call level is not the highest requested");

  property p_preempt;
    vectorCall_q |-> (!$past(svcAny) || callLevel_q > $past(svcTop));
  endproperty
  a_preempt: assert property (p_preempt) // R2 R7
    else $error("call at or below level in service");

  property p_top_locked;
    vectorCall_q |-> !$past(inService_q[3]);
  endproperty
  a_top_locked: assert property (p_top_locked) // R3
    else $error("level 3 service was preempted");

  property p_conditions;
    vectorCall_q |-> $past(lastCycle && !writesIntReg &&
                           !returnFromInterrupt && mcEnd);
  endproperty
  a_conditions: assert property (p_conditions) // R6 R8
    else $error("call issued with blocked condition");

  property p_gate;
    vectorCall_q |-> $past(baseEnableReg[GATE_BIT] && sample_q[winIdx]);
  endproperty
  a_gate: assert property (p_gate) // R9 R15 R21
    else $error("call without live enabled request");

  property p_clear;
    (clrTimer0Flag || clrTimer1Flag || clrExt0Flag || clrExt1Flag)
      |-> vectorCall_q;
  endproperty
  a_clear: assert property (p_clear) // R10
    else $error("flag clear outside a call");

  sequence s_call_body;
    callBusy_q [*8] ##1 callBusy_q [*8];
  endsequence
  property p_call_len;
    vectorCall_q |-> s_call_body ##1 (loadPc_q && !callBusy_q);
  endproperty
  a_call_len: assert property (p_call_len) // R18
    else $error("call not four machine cycles");

  property p_vector;
    loadPc_q |-> vectorAddr_q == SRC_VECTOR[callIdx_q];
  endproperty
  a_vector: assert property (p_vector) // R11 R12
    else $error("wrong vector address at load");

  property p_release;
    retire && svcAny |=>
      $countones(inService_q) == $countones($past(inService_q)) - 1;
  endproperty
  a_release: assert property (p_release) // R13
    else $error("return did not release one level");

  property p_keep;
    !startCall && !retire |=> $stable(inService_q);
  endproperty
  a_keep: assert property (p_keep) // R14
    else $error("in-service changed without call or return");

  property p_sample;
    !$past(mcEnd) |-> $stable(sample_q);
  endproperty
  a_sample: assert property (p_sample) // R17
    else $error("samples changed mid machine cycle");

endmodule : flic_ctrl
`default_nettype wire

// file: flic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module flic_core_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        vectorCall,
  input  wire logic        loadPc,
  input  wire logic [15:0] vectorAddr,
  output logic      [15:0] pc,
  output logic      [3:0]  depth
);
  // core side: call pushes the return address only, then takes the vector
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc    <= 16'h0100;
      depth <= 4'h0;
    end else begin
      if (vectorCall) begin
        depth <= depth + 4'h1;
      end
      if (loadPc) begin
        pc <= vectorAddr;
      end
    end
  end
endmodule : flic_core_model
`default_nettype wire

// file: flic_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flic_ctrl_tb_top;
  import flic_pkg::*;
  localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h0043, 16'h0053,
    16'h000b, 16'h0033, 16'h005b, 16'h0013, 16'h003b, 16'h001b, 16'h0023,
    16'h0073, 16'h004b, 16'h002b, 16'h0063};
  // enable position per source, bits 15:8 are the extended register
  localparam logic [3:0] EPOS [NSRC] = '{4'h0, 4'h5, 4'hc, 4'h1, 4'h8,
    4'h6, 4'h2, 4'h9, 4'h3, 4'h4, 4'hd, 4'he, 4'hf, 4'ha};
  logic ref_clk, resetn, gate, ext0EdgeMode, ext1EdgeMode, converterOnRc;
  logic lastCycle, writesIntReg, returnFromInterrupt;
  logic [NSRC-1:0] flg, en;
  logic [1:0] lv [NSRC];
  logic [15:0] enR, loR, hiR, vectorAddr, pc;
  logic cycleEnd, vectorCall, loadPc, callBusy, clrExt0Flag, clrExt1Flag;
  logic clrTimer0Flag, clrTimer1Flag, wakeRequest;
  logic [3:0] inService, depth;
  int n_mismatch, check_count, n_call;

  always_comb begin
    logic [3:0] pp;
    pp = 4'h0;
    enR = 16'h0;
    loR = 16'h0;
    hiR = 16'h0;
    for (int i = 0; i < NSRC; i++) begin
      pp = (i == 13) ? 4'h7 : EPOS[i];
      enR[EPOS[i]] = en[i];
      loR[pp] = lv[i][0];
      hiR[pp] = lv[i][1];
    end
    enR[7] = gate;
  end

  flic_ctrl flic_ctrl_i (.ref_clk, .resetn,
    .baseEnableReg(enR[7:0]), .extendedEnableReg(enR[15:8]),
    .basePriorityLow(loR[7:0]), .basePriorityHigh(hiR[7:0]),
    .extendedPriorityLow(loR[15:8]), .extendedPriorityHigh(hiR[15:8]),
    .ext0RequestFlag(flg[0]), .ext1RequestFlag(flg[6]), .ext0EdgeMode,
    .ext1EdgeMode, .timer0OverflowFlag(flg[3]), .timer1OverflowFlag(flg[8]),
    .timer2EventFlag(flg[12]), .serialRxFlag(flg[9]), .serialTxFlag(1'b0),
    .brownoutFlag(flg[1]), .watchdogFlag(flg[2]),
    .keypadFlags({7'h0, flg[7]}), .captureFlags({2'h0, flg[13]}),
    .pwmBrakeFlag(flg[10]), .converterDoneFlag(flg[5]), .converterOnRc,
    .twoWireFlag(flg[4]), .spiFlag(flg[11]), .lastCycle, .writesIntReg,
    .returnFromInterrupt, .cycleEnd, .vectorCall, .loadPc, .vectorAddr,
    .callBusy, .inService, .clrExt0Flag, .clrExt1Flag, .clrTimer0Flag,
    .clrTimer1Flag, .wakeRequest);

  flic_core_model flic_core_model_i (.ref_clk, .resetn, .vectorCall,
    .loadPc, .vectorAddr, .pc, .depth);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic no_call(input int k);
    int hits;
    int ends;
    hits = 0;
    ends = 0;
    repeat (k) begin
      @(posedge ref_clk);
      #1 hits += (vectorCall === 1'b1);
      ends += (cycleEnd === 1'b1);
    end
    check("refused call", 16'(hits), 16'h0);
    check("cycle ends", 16'(ends), 16'(k / CLK_PER_MC));
  endtask : no_call

  task automatic expect_call(input int s, input logic [3:0] svc);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (vectorCall !== 1'b1 && n < 40);
    if (vectorCall !== 1'b1) begin
      n_mismatch++;
      close_out;
    end
    check("vector", vectorAddr, VEC[s]);
    check("clears", {12'h0, clrExt0Flag, clrExt1Flag, clrTimer0Flag,
      clrTimer1Flag}, {12'h0, s == 0, 1'b0, s == 3, s == 8});
    check("in service", {12'h0, inService}, {12'h0, svc});
    check("busy at call", {15'h0, callBusy}, 16'h1);
    @(posedge ref_clk);
    flg <= '0;
    #1 n = 1;
    while (loadPc !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("call span", 16'(n), 16'd16);
    check("busy at load", {15'h0, callBusy}, 16'h0);
    @(posedge ref_clk);
    #1 check("pc", pc, VEC[s]);
    n_call++;
    check("calls pushed", {12'h0, depth}, {12'h0, 4'(n_call)});
  endtask : expect_call

  task automatic return_from_interrupt(input logic [3:0] svc);
    @(posedge ref_clk);
    returnFromInterrupt <= 1'b1;
    repeat (4) @(posedge ref_clk);
    returnFromInterrupt <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("released", {12'h0, inService}, {12'h0, svc});
  endtask : return_from_interrupt

  task automatic s_vectors;
    for (int s = 0; s < NSRC; s++) begin
      @(posedge ref_clk);
      flg <= 14'h1 << s;
      expect_call(s, 4'h1);
      return_from_interrupt(4'h0);
    end
  endtask : s_vectors

  task automatic s_rank;
    @(posedge ref_clk);
    flg <= '1;
    expect_call(0, 4'h1);
    return_from_interrupt(4'h0);
    @(posedge ref_clk);
    lv[12] <= 2'b01;
    lv[13] <= 2'b10;
    flg <= '1;
    expect_call(13, 4'h4);
    return_from_interrupt(4'h0);
  endtask : s_rank

  task automatic s_nest;
    @(posedge ref_clk);
    lv <= '{8: 2'b01, 9: 2'b01, 1: 2'b10, 2: 2'b11, 0: 2'b11,
            default: 2'b00};
    flg <= 14'h1 << 8;
    expect_call(8, 4'h2);
    flg <= 14'h1 << 9;
    no_call(24);
    flg <= 14'h1 << 9 | 14'h1 << 1;
    expect_call(1, 4'h6);
    flg <= 14'h1 << 2;
    expect_call(2, 4'he);
    flg <= 14'h1;
    no_call(24);
    flg <= '0;
    return_from_interrupt(4'h6);
    return_from_interrupt(4'h2);
    return_from_interrupt(4'h0);
  endtask : s_nest

  task automatic s_refuse;
    @(posedge ref_clk);
    lv <= '{default: 2'b00};
    gate <= 1'b0;
    flg <= 14'h1 << 3;
    no_call(24);
    gate <= 1'b1;
    en[3] <= 1'b0;
    no_call(24);
    en[3] <= 1'b1;
    lastCycle <= 1'b0;
    no_call(24);
    lastCycle <= 1'b1;
    writesIntReg <= 1'b1;
    no_call(24);
    writesIntReg <= 1'b0;
    expect_call(3, 4'h1);
    return_from_interrupt(4'h0);
    @(posedge ref_clk);
    lastCycle <= 1'b0;
    flg <= 14'h1 << 3;
    repeat (12) @(posedge ref_clk);
    flg <= '0;
    repeat (8) @(posedge ref_clk);
    lastCycle <= 1'b1;
    no_call(24);
  endtask : s_refuse

  task automatic wake_is(input int s, input logic rc, input logic w);
    @(posedge ref_clk);
    gate <= 1'b0;
    flg <= 14'h1 << s;
    converterOnRc <= rc;
    repeat (6) @(posedge ref_clk);
    #1 check("wake", {15'h0, wakeRequest}, {15'h0, w});
  endtask : wake_is

  initial begin
    resetn = 1'b0;
    gate = 1'b1;
    en = '1;
    flg = '0;
    lv = '{default: 2'b00};
    ext0EdgeMode = 1'b1;
    ext1EdgeMode = 1'b0;
    converterOnRc = 1'b0;
    lastCycle = 1'b1;
    writesIntReg = 1'b0;
    returnFromInterrupt = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    n_call = 0;
    @(posedge ref_clk);
    #1 check("reset vector", vectorAddr, 16'h0000);
    check("reset outs", {7'h0, vectorCall, loadPc, callBusy, wakeRequest,
      cycleEnd, inService}, 16'h0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    s_vectors;
    s_rank;
    s_nest;
    s_refuse;
    wake_is(3, 1'b0, 1'b0);
    wake_is(0, 1'b0, 1'b1);
    wake_is(7, 1'b0, 1'b1);
    wake_is(5, 1'b0, 1'b0);
    wake_is(5, 1'b1, 1'b1);
    close_out;
  end
endmodule : flic_ctrl_tb_top
`default_nettype wire
